// >>> verilog/pwrbtn_pkg.sv
// Functional notes
// - The debounce duration for the button is selectable among 0, 50, 100 and 500 ms.
// - The off-to-on press duration is selectable among the same 0, 50, 100 and 500 ms.
// - In the ON state a press held longer than the debounce duration raises the power-off interrupt.
// - In the OFF state a press held longer than the off-to-on duration requests power-on and enters ON.
// - The maximum hold time-out is selectable among 5, 10 and 15 s, or disabled.
// - With the time-out enabled, a press held in the ON state for the selected time issues a power-down request.
`default_nettype none
package pwrbtn_pkg;
  // ==========================================================================
  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned T_SHORT_MS = 50;
  localparam int unsigned T_MID_MS = 100;
  localparam int unsigned T_LONG_MS = 500;
  localparam int unsigned T_TO1_S = 5;
  localparam int unsigned T_TO2_S = 10;
  localparam int unsigned T_TO3_S = 15;
  localparam int unsigned S_MS = 1000;
  localparam int unsigned CNT_W = 32;
  // ==========================================================================
  // Selector encodings.
  localparam logic [1:0] SEL_0MS = 2'h0;
  localparam logic [1:0] SEL_50MS = 2'h1;
  localparam logic [1:0] SEL_100MS = 2'h2;
  localparam logic [1:0] SEL_500MS = 2'h3;
  localparam logic [1:0] TO_OFF = 2'h0;
  localparam logic [1:0] TO_5S = 2'h1;
  localparam logic [1:0] TO_10S = 2'h2;
  localparam logic [1:0] TO_15S = 2'h3;
  typedef enum logic {PWRBTN_OFF, PWRBTN_ON} pwrbtn_state_t;
endpackage : pwrbtn_pkg
`default_nettype wire

// >>> verilog/pwrbtn_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pwrbtn_ctrl
  import pwrbtn_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Button pin, high while pressed.
  input wire logic power_button_in,
  // Configuration.
  input wire logic [1:0] debounce_sel,
  input wire logic [1:0] off_to_on_sel,
  input wire logic [1:0] max_timeout_sel,
  // Power state and events.
  output logic power_on,
  output logic power_off_irq,
  output logic power_on_req,
  output logic power_down_req
);
  // ==========================================================================
  // Threshold selection.
  function automatic logic [CNT_W-1:0] short_lim(input logic [1:0] sel);
    logic [CNT_W-1:0] v;
    v = '0;
    case (sel)
      SEL_50MS: v = CNT_W'(T_SHORT_MS * MS_CYC);
      SEL_100MS: v = CNT_W'(T_MID_MS * MS_CYC);
      SEL_500MS: v = CNT_W'(T_LONG_MS * MS_CYC);
      default: v = '0;
    endcase
    return v;
  endfunction : short_lim

  logic [CNT_W-1:0] to_lim;
  always_comb begin
    case (max_timeout_sel)
      TO_5S: to_lim = CNT_W'(T_TO1_S * S_MS * MS_CYC);
      TO_10S: to_lim = CNT_W'(T_TO2_S * S_MS * MS_CYC);
      TO_15S: to_lim = CNT_W'(T_TO3_S * S_MS * MS_CYC);
      default: to_lim = '0;
    endcase
  end

  // ==========================================================================
  // Synchroniser. The first stage feeds only the second, so a metastable
  // first flop never reaches the counters or the state.
  logic sync1_r;
  logic sync1_nxt;
  logic sync2_r;
  logic sync2_nxt;
  logic pressed;

  always_comb begin
    sync1_nxt = power_button_in;
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  assign pressed = sync2_r;

  // ==========================================================================
  // Press counter. It saturates rather than wraps, so a button held for
  // hours cannot fire an event a second time.
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (!pressed) begin
      cnt_nxt = '0;
    end else if (cnt_r != '1) begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================================
  // Threshold compare.
  logic [CNT_W-1:0] db_lim;
  logic [CNT_W-1:0] oo_lim;
  logic to_en;
  logic db_hit;
  logic oo_hit;
  logic to_hit;

  always_comb begin
    db_lim = short_lim(debounce_sel);
    oo_lim = short_lim(off_to_on_sel);
    to_en = (max_timeout_sel != TO_OFF);
    db_hit = (cnt_r >= db_lim);
    oo_hit = (cnt_r >= oo_lim);
    to_hit = to_en && (cnt_r >= to_lim);
  end

  // ==========================================================================
  // Power state and arming flags, declared here because the decode reads them.
  pwrbtn_state_t state_r;
  pwrbtn_state_t state_nxt;
  logic irq_done_r;
  logic irq_done_nxt;
  logic dn_done_r;
  logic dn_done_nxt;
  logic fire_irq;
  logic fire_on;
  logic fire_dn;

  // ==========================================================================
  // Event decode. Each event fires once per press; a held button never repeats it.
  always_comb begin
    fire_irq = 1'b0;
    fire_on = 1'b0;
    fire_dn = 1'b0;
    if (pressed) begin
      case (state_r)
        PWRBTN_ON: begin
          fire_irq = !irq_done_r && db_hit;
          fire_dn = !dn_done_r && to_hit;
        end
        default: begin
          // A press that has just powered down must be released before it can power on.
          fire_on = !dn_done_r && oo_hit;
        end
      endcase
    end
  end

  // ==========================================================================
  // Arming flags. The power-on press also marks both power-off events as
  // spent, so the same press cannot turn the processor straight off again.
  always_comb begin
    irq_done_nxt = irq_done_r;
    dn_done_nxt = dn_done_r;
    if (!pressed) begin
      irq_done_nxt = 1'b0;
      dn_done_nxt = 1'b0;
    end else begin
      if (fire_irq || fire_on) begin
        irq_done_nxt = 1'b1;
      end
      if (fire_dn || fire_on) begin
        dn_done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_done_r <= 1'b0;
      dn_done_r <= 1'b0;
    end else begin
      irq_done_r <= irq_done_nxt;
      dn_done_r <= dn_done_nxt;
    end
  end

  // ==========================================================================
  // Power state. Reset leaves the processor on, as after a cold reset.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PWRBTN_ON: begin
        if (fire_dn) begin
          state_nxt = PWRBTN_OFF;
        end
      end
      default: begin
        if (fire_on) begin
          state_nxt = PWRBTN_ON;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= PWRBTN_ON;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Event pulses, registered so that each output is a clean one-cycle strobe.
  logic irq_r;
  logic irq_nxt;
  logic onreq_r;
  logic onreq_nxt;
  logic dnreq_r;
  logic dnreq_nxt;

  always_comb begin
    irq_nxt = fire_irq;
    onreq_nxt = fire_on;
    dnreq_nxt = fire_dn;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
      onreq_r <= 1'b0;
      dnreq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
      onreq_r <= onreq_nxt;
      dnreq_r <= dnreq_nxt;
    end
  end

  // ==========================================================================
  // Outputs.
  assign power_on = (state_r == PWRBTN_ON);
  assign power_off_irq = irq_r;
  assign power_on_req = onreq_r;
  assign power_down_req = dnreq_r;
endmodule : pwrbtn_ctrl
`default_nettype wire

// >>> bench/pwrbtn_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pwrbtn_chk (
  input wire logic ref_clk, nrst, power_button_in,
  input wire logic [1:0] debounce_sel, off_to_on_sel, max_timeout_sel,
  input wire logic power_on, power_off_irq, power_on_req, power_down_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_IRQ_ONCE: assert property (power_off_irq |=> !power_off_irq) else $error("irq long");
  AST_IRQ_ON: assert property (power_off_irq |-> power_on) else $error("irq in off");
  AST_ONREQ: assert property (power_on_req |-> power_on && !$past(power_on)) else $error("on");
  AST_DOWN: assert property (power_down_req |-> !power_on && $past(power_on)) else $error("dn");
  AST_NO_TO: assert property (max_timeout_sel == 2'h0 |-> !power_down_req) else $error("to");
  AST_STATE: assert property ($changed(power_on) |-> power_on_req || power_down_req)
    else $error("state moved alone");
  AST_REL: assert property (!power_button_in [*4] |=> !(power_off_irq || power_on_req))
    else $error("event after release");
  AST_DB0: assert property (power_on && debounce_sel == 2'h0 && $rose(power_button_in)
    |-> ##[1:6] power_off_irq) else $error("zero debounce late");
endmodule : pwrbtn_chk
`default_nettype wire

// >>> bench/pwrbtn_button.sv
`timescale 1ns/1ps
`default_nettype none
module pwrbtn_button (
  input wire logic ref_clk,
  output logic pin
);
  initial pin = 1'b0;
  // Bounce is not modelled, so a press is one clean level held for n cycles.
  task automatic press(input int n);
    pin = 1'b1;
    repeat (n) @(negedge ref_clk);
    pin = 1'b0;
    repeat (20) @(negedge ref_clk);
  endtask : press
endmodule : pwrbtn_button
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pwrbtn_pkg::*;
  // ==========================================================================
  // Setup. A short millisecond keeps the fifteen second hold near 30000 cycles.
  localparam int MSC = 2;
  typedef struct {logic [1:0] sel; int dlt; int exp;} pwrbtn_row_t;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] db = 2'h0, oo = 2'h0, to = 2'h0;
  logic pin, pon, irq, onr, dnr;
  int fails = 0, total_checks = 0, cyc = 0, n_irq = 0, n_on = 0, n_dn = 0;
  int ms[4] = '{0, T_SHORT_MS, T_MID_MS, T_LONG_MS};
  pwrbtn_row_t rows[7] = '{'{2'h0, 10, 1}, '{2'h1, -10, 0}, '{2'h1, 10, 1},
    '{2'h2, -10, 0}, '{2'h2, 10, 1}, '{2'h3, -10, 0}, '{2'h3, 10, 1}};
  pwrbtn_button btn (.ref_clk(ref_clk), .pin(pin));
  pwrbtn_ctrl #(.MS_CYC(MSC)) dut (.ref_clk(ref_clk), .nrst(nrst), .power_button_in(pin),
    .debounce_sel(db), .off_to_on_sel(oo), .max_timeout_sel(to), .power_on(pon),
    .power_off_irq(irq), .power_on_req(onr), .power_down_req(dnr));
  always #5 ref_clk = ~ref_clk;
  // Pulses are counted on the falling edge, where the registered outputs have settled.
  always @(negedge ref_clk) begin
    cyc++;
    n_irq += irq;
    n_on += onr;
    n_dn += dnr;
    if (cyc == 100000) begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic clr();
    n_irq = 0;
    n_on = 0;
    n_dn = 0;
  endtask : clr
  task automatic final_report();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Tests. Presses sit ten cycles either side of each non-zero debounce and off-to-on threshold, and ten past each time-out.
  initial begin
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    chk(pon, 1);
    foreach (rows[i]) begin
      db = rows[i].sel;
      clr();
      btn.press(ms[rows[i].sel] * MSC + rows[i].dlt);
      chk(n_irq, rows[i].exp);
      chk(n_dn, 0);
      $display("row %0d done", i);
    end
    db = SEL_0MS;
    for (int t = 1; t < 4; t++) begin
      to = 2'(t);
      oo = 2'(t);
      clr();
      btn.press(t * T_TO1_S * S_MS * MSC + 10);
      chk(n_irq + 2 * n_dn, 3);
      chk(pon, 0);
      btn.press(ms[t] * MSC - 10);
      chk(n_on, 0);
      btn.press(ms[t] * MSC + 10);
      chk(n_on + 2 * pon, 3);
      $display("timeout %0d done", t);
    end
    to = TO_5S;
    btn.press(T_TO1_S * S_MS * MSC + 10);
    chk(pon, 0);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    chk(pon, 1);
    $display("mid reset done");
    final_report();
  end
endmodule : testbench
bind pwrbtn_ctrl pwrbtn_chk chk (.*);
`default_nettype wire
